// [rtl/ptc_cfg.svh]
// Register map, field positions and widths of the pin trigger/timestamp control
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_ADDR_W 12
`define PTC_OFS_CTRL 12'h52C
`define PTC_OFS_TGT_NS 12'h530
`define PTC_OFS_TGT_S 12'h534
`define PTC_OFS_INDEX 12'h520
`define PTC_OFS_STAT 12'h524
`define PTC_OFS_CFG 12'h538
`define PTC_B_OUT_SEL 8
`define PTC_B_PIN_IN 7
`define PTC_B_DIR 6
`define PTC_B_IRQ_EN 5
`define PTC_B_RUNNING 4
`define PTC_B_ARM 3
`define PTC_B_CMP_CLR 2
`define PTC_B_CAP_ARM 1
`define PTC_B_CAP_CLR 0
`define PTC_B_IDX_CAP 8
`define PTC_B_ERR_LO 16
`define PTC_B_NOW 25
`define PTC_B_NOTIFY 24
`define PTC_NS_W 30
`define PTC_TALLY_W 8
`define PTC_ZERO32 32'h0000_0000
`endif

// [rtl/ptc_pkg.sv]
// Types shared by the pin trigger/timestamp control modules
package ptc_pkg;
    typedef enum logic [1:0] {
        PTC_IDLE,
        PTC_ARMED,
        PTC_FIRED
    } ptc_cmp_state_t;
    typedef logic [31:0] ptc_word_t;
endpackage

// [rtl/ptc_cmp_if.sv]
// Interface between the control core and one compare unit
`timescale 1ns/10ps
interface ptc_cmp_if;
    logic arm_set;
    logic disarm;
    logic soft_clear;
    logic fire_now;
    logic [29:0] tgt_ns;
    logic [31:0] tgt_s;
    logic armed;
    logic running;
    logic fire;
    logic late;
    modport ctl (output arm_set, disarm, soft_clear, fire_now, tgt_ns, tgt_s,
                 input armed, running, fire, late);
    modport unit (input arm_set, disarm, soft_clear, fire_now, tgt_ns, tgt_s,
                  output armed, running, fire, late);
endinterface

// [rtl/ptc_cmp_unit.sv]
// One compare unit: arms, compares system time with its target, fires once
`timescale 1ns/10ps
module ptc_cmp_unit
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // System time
    input wire logic [31:0] sys_s,
    input wire logic [29:0] sys_ns,
    // Control side
    ptc_cmp_if.unit cu
);
    ptc_cmp_state_t st_r, st_nxt;
    logic reached, passed, fire_c;
    logic early_r, early_nxt;

    always_comb begin
        reached = (sys_s > cu.tgt_s) || ((sys_s == cu.tgt_s) && (sys_ns >= cu.tgt_ns));
        passed = (sys_s > cu.tgt_s) || ((sys_s == cu.tgt_s) && (sys_ns > cu.tgt_ns));
        fire_c = 1'b0;
        st_nxt = st_r;
        case (st_r)
            PTC_IDLE: begin
                if (cu.arm_set) begin
                    st_nxt = PTC_ARMED;
                end
            end
            PTC_ARMED: begin
                if (passed && cu.fire_now) begin
                    fire_c = 1'b1;
                    st_nxt = PTC_FIRED;
                end else if (reached && (!passed || early_r)) begin
                    fire_c = 1'b1;
                    st_nxt = PTC_FIRED;
                end
            end
            PTC_FIRED: begin
                if (cu.arm_set) begin
                    st_nxt = PTC_ARMED;
                end
            end
            default: st_nxt = PTC_IDLE;
        endcase
        if (cu.soft_clear || cu.disarm) begin
            st_nxt = PTC_IDLE;
            fire_c = 1'b0;
        end
        // Target still ahead: a later jump past it must fire, not err
        early_nxt = (st_nxt == PTC_ARMED) && !reached;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= PTC_IDLE;
            early_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            early_r <= early_nxt;
        end
    end

    assign cu.fire = fire_c;
    assign cu.armed = (st_r == PTC_ARMED);
    // Late target seen while armed and no immediate fire
    assign cu.late = (st_r == PTC_ARMED) && passed && !cu.fire_now && !early_r;
    assign cu.running = (st_r == PTC_ARMED) && !cu.late;
endmodule

// [rtl/ptc_cap_unit.sv]
// One capture unit: arm, soft clear, event tally and result flags
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_cap_unit
    import ptc_pkg::*;
#(
    parameter int TALLY_W = `PTC_TALLY_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Commands
    input wire logic arm_wr,
    input wire logic arm_val,
    input wire logic soft_clear,
    input wire logic evt,
    // State
    output logic armed,
    output logic valid,
    output logic ovfl,
    output logic [TALLY_W-1:0] tally
);
    logic armed_r, armed_nxt, valid_r, valid_nxt, ovfl_r, ovfl_nxt;
    logic [TALLY_W-1:0] tally_r, tally_nxt;

    always_comb begin
        armed_nxt = armed_r;
        valid_nxt = valid_r;
        ovfl_nxt = ovfl_r;
        tally_nxt = tally_r;
        if (armed_r && evt) begin
            valid_nxt = 1'b1;
            if (&tally_r) begin
                ovfl_nxt = 1'b1;
            end else begin
                tally_nxt = tally_r + 1'b1;
            end
        end
        if (arm_wr && arm_val) begin
            armed_nxt = 1'b1;
            tally_nxt = '0;
        end else if (arm_wr) begin
            armed_nxt = 1'b0;
            valid_nxt = 1'b0;
            ovfl_nxt = 1'b0;
        end
        if (soft_clear) begin
            armed_nxt = 1'b0;
            valid_nxt = 1'b0;
            ovfl_nxt = 1'b0;
            tally_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_r <= 1'b0;
            valid_r <= 1'b0;
            ovfl_r <= 1'b0;
            tally_r <= '0;
        end else begin
            armed_r <= armed_nxt;
            valid_r <= valid_nxt;
            ovfl_r <= ovfl_nxt;
            tally_r <= tally_nxt;
        end
    end

    assign armed = armed_r;
    assign valid = valid_r;
    assign ovfl = ovfl_r;
    assign tally = tally_r;
endmodule

// [rtl/ptc_top.sv]
// Pin trigger and timestamp unit control with Avalon-MM register slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_top
    import ptc_pkg::*;
#(
    parameter int N_CMP = 3,
    parameter int N_CAP = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // System time
    input wire logic [31:0] sys_s,
    input wire logic [29:0] sys_ns,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Unit events
    output logic [N_CMP-1:0] cmp_fire,
    output logic [N_CAP-1:0] capture_irq
);
    // ****************************************
    // Register state
    // ****************************************
    logic [1:0] cmp_idx_r, cmp_idx_nxt;
    logic cap_idx_r, cap_idx_nxt;
    logic out_sel_r, out_sel_nxt, dir_r, dir_nxt;
    logic [N_CAP-1:0] irq_en_r, irq_en_nxt;
    logic [N_CMP-1:0] now_r, now_nxt, notify_r, notify_nxt;
    logic [N_CMP-1:0] done_r, done_nxt, err_r, err_nxt;
    logic [29:0] tgt_ns_r [N_CMP], tgt_ns_nxt [N_CMP];
    logic [31:0] tgt_s_r [N_CMP], tgt_s_nxt [N_CMP];
    logic ack_r, ack_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic pin_q_r, pin_q_nxt, pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
    logic [N_CMP-1:0] fire_r;
    logic [N_CAP-1:0] irq_r, irq_nxt;

    // ****************************************
    // Bus decode
    // ****************************************
    logic wr, rd, ctrl_wr, ns_wr, s_wr, idx_wr, stat_wr, cfg_wr;
    logic [31:0] wmask, wd;
    always_comb begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wd = avs_writedata;
        wr = avs_write && !ack_r;
        rd = avs_read && !ack_r;
        ctrl_wr = wr && (avs_address == `PTC_OFS_CTRL);
        ns_wr = wr && (avs_address == `PTC_OFS_TGT_NS);
        s_wr = wr && (avs_address == `PTC_OFS_TGT_S);
        idx_wr = wr && (avs_address == `PTC_OFS_INDEX);
        stat_wr = wr && (avs_address == `PTC_OFS_STAT);
        cfg_wr = wr && (avs_address == `PTC_OFS_CFG);
    end

    // ****************************************
    // Units
    // ****************************************
    ptc_cmp_if cmp_bus [N_CMP] ();
    logic [N_CMP-1:0] c_armed, c_running, c_fire, c_late;
    logic [N_CAP-1:0] k_armed, k_valid, k_ovfl;
    logic [`PTC_TALLY_W-1:0] k_tally [N_CAP];
    logic cap_evt;
    assign cap_evt = dir_r && pin_in && !pin_q_r;

    genvar gi;
    generate
        for (gi = 0; gi < N_CMP; gi++) begin : g_cmp
            logic sel;
            assign sel = (cmp_idx_r == 2'(gi));
            assign cmp_bus[gi].arm_set = ctrl_wr && sel && avs_byteenable[0] &&
                                         wd[`PTC_B_ARM];
            assign cmp_bus[gi].disarm = ctrl_wr && sel && avs_byteenable[0] &&
                                        !wd[`PTC_B_ARM];
            assign cmp_bus[gi].soft_clear = ctrl_wr && sel && avs_byteenable[0] &&
                                            wd[`PTC_B_CMP_CLR];
            assign cmp_bus[gi].fire_now = now_r[gi];
            assign cmp_bus[gi].tgt_ns = tgt_ns_r[gi];
            assign cmp_bus[gi].tgt_s = tgt_s_r[gi];
            assign c_armed[gi] = cmp_bus[gi].armed;
            assign c_running[gi] = cmp_bus[gi].running;
            assign c_fire[gi] = cmp_bus[gi].fire;
            assign c_late[gi] = cmp_bus[gi].late;
            ptc_cmp_unit u_cmp (
                .clk(clk),
                .rst(rst),
                .sys_s(sys_s),
                .sys_ns(sys_ns),
                .cu(cmp_bus[gi])
            );
        end
        for (gi = 0; gi < N_CAP; gi++) begin : g_cap
            logic sel;
            assign sel = (cap_idx_r == 1'(gi));
            ptc_cap_unit #(
                .TALLY_W(`PTC_TALLY_W)
            ) u_cap (
                .clk(clk),
                .rst(rst),
                .arm_wr(ctrl_wr && sel && avs_byteenable[0]),
                .arm_val(wd[`PTC_B_CAP_ARM]),
                .soft_clear(ctrl_wr && sel && avs_byteenable[0] && wd[`PTC_B_CAP_CLR]),
                .evt(cap_evt),
                .armed(k_armed[gi]),
                .valid(k_valid[gi]),
                .ovfl(k_ovfl[gi]),
                .tally(k_tally[gi])
            );
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        cmp_idx_nxt = cmp_idx_r;
        cap_idx_nxt = cap_idx_r;
        out_sel_nxt = out_sel_r;
        dir_nxt = dir_r;
        irq_en_nxt = irq_en_r;
        now_nxt = now_r;
        notify_nxt = notify_r;
        done_nxt = done_r;
        err_nxt = err_r;
        tgt_ns_nxt = tgt_ns_r;
        tgt_s_nxt = tgt_s_r;
        if (idx_wr && avs_byteenable[0]) begin
            cmp_idx_nxt = wd[1:0];
        end
        if (idx_wr && avs_byteenable[1]) begin
            cap_idx_nxt = wd[`PTC_B_IDX_CAP];
        end
        if (ctrl_wr && avs_byteenable[1]) begin
            out_sel_nxt = wd[`PTC_B_OUT_SEL];
        end
        if (ctrl_wr && avs_byteenable[0]) begin
            dir_nxt = wd[`PTC_B_DIR];
            irq_en_nxt[cap_idx_r] = wd[`PTC_B_IRQ_EN];
        end
        if (cfg_wr && avs_byteenable[3]) begin
            now_nxt[cmp_idx_r] = wd[`PTC_B_NOW];
            notify_nxt[cmp_idx_r] = wd[`PTC_B_NOTIFY];
        end
        if (stat_wr) begin
            done_nxt = done_r & ~(wd[N_CMP-1:0] & wmask[N_CMP-1:0]);
        end
        for (int i = 0; i < N_CMP; i++) begin
            if (ns_wr && cmp_idx_r == i[1:0]) begin
                tgt_ns_nxt[i] = (tgt_ns_r[i] & ~wmask[29:0]) |
                                (wd[29:0] & wmask[29:0]);
            end
            if (s_wr && cmp_idx_r == i[1:0]) begin
                tgt_s_nxt[i] = (tgt_s_r[i] & ~wmask) | (wd & wmask);
            end
            if (!c_armed[i]) begin
                err_nxt[i] = 1'b0;
            end
            if (c_late[i] && notify_r[i]) begin
                err_nxt[i] = 1'b1;
            end
            if (c_fire[i] && notify_r[i]) begin
                done_nxt[i] = 1'b1;
            end
            if (ctrl_wr && avs_byteenable[0] && wd[`PTC_B_CMP_CLR] &&
                cmp_idx_r == i[1:0]) begin
                now_nxt[i] = 1'b0;
                notify_nxt[i] = 1'b0;
                err_nxt[i] = 1'b0;
            end
        end
        // Pin path: through fire_r and then pin_out_r by default, through pin_out_r only when selected
        pin_q_nxt = pin_in;
        pin_oe_nxt = !dir_nxt;
        pin_out_nxt = out_sel_r ? |c_fire : |fire_r;
        irq_nxt = k_valid & irq_en_r;
        // Bus answer one cycle after the request
        ack_nxt = (avs_read || avs_write) && !ack_r;
        wait_nxt = !ack_nxt;
        rdata_nxt = rdata_r;
        if (rd) begin
            rdata_nxt = `PTC_ZERO32;
            case (avs_address)
                `PTC_OFS_CTRL: begin
                    rdata_nxt[`PTC_B_OUT_SEL] = out_sel_r;
                    rdata_nxt[`PTC_B_PIN_IN] = pin_in;
                    rdata_nxt[`PTC_B_DIR] = dir_r;
                    rdata_nxt[`PTC_B_IRQ_EN] = irq_en_r[cap_idx_r];
                    rdata_nxt[`PTC_B_RUNNING] = c_running[cmp_idx_r];
                    rdata_nxt[`PTC_B_ARM] = c_armed[cmp_idx_r];
                    rdata_nxt[`PTC_B_CAP_ARM] = k_armed[cap_idx_r];
                end
                `PTC_OFS_TGT_NS: rdata_nxt[29:0] = tgt_ns_r[cmp_idx_r];
                `PTC_OFS_TGT_S: rdata_nxt = tgt_s_r[cmp_idx_r];
                `PTC_OFS_INDEX: begin
                    rdata_nxt[1:0] = cmp_idx_r;
                    rdata_nxt[`PTC_B_IDX_CAP] = cap_idx_r;
                end
                `PTC_OFS_STAT: begin
                    rdata_nxt[N_CMP-1:0] = done_r;
                    rdata_nxt[`PTC_B_ERR_LO +: N_CMP] = err_r;
                end
                `PTC_OFS_CFG: begin
                    rdata_nxt[`PTC_B_NOW] = now_r[cmp_idx_r];
                    rdata_nxt[`PTC_B_NOTIFY] = notify_r[cmp_idx_r];
                    rdata_nxt[`PTC_TALLY_W+7:8] = k_tally[cap_idx_r];
                    rdata_nxt[1] = k_ovfl[cap_idx_r];
                    rdata_nxt[0] = k_valid[cap_idx_r];
                end
                default: rdata_nxt = `PTC_ZERO32;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_idx_r <= '0;
            cap_idx_r <= 1'b0;
            out_sel_r <= 1'b0;
            dir_r <= 1'b0;
            irq_en_r <= '0;
            now_r <= '0;
            notify_r <= '0;
            done_r <= '0;
            err_r <= '0;
            for (int i = 0; i < N_CMP; i++) begin
                tgt_ns_r[i] <= '0;
                tgt_s_r[i] <= `PTC_ZERO32;
            end
            ack_r <= 1'b0;
            wait_r <= 1'b1;
            rdata_r <= `PTC_ZERO32;
            pin_q_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b1;
            fire_r <= '0;
            irq_r <= '0;
        end else begin
            cmp_idx_r <= cmp_idx_nxt;
            cap_idx_r <= cap_idx_nxt;
            out_sel_r <= out_sel_nxt;
            dir_r <= dir_nxt;
            irq_en_r <= irq_en_nxt;
            now_r <= now_nxt;
            notify_r <= notify_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            tgt_ns_r <= tgt_ns_nxt;
            tgt_s_r <= tgt_s_nxt;
            ack_r <= ack_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            pin_q_r <= pin_q_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            fire_r <= c_fire;
            irq_r <= irq_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign cmp_fire = fire_r;
    assign capture_irq = irq_r;
endmodule

// [testbench/ptc_top_properties.sv]
// Port-level properties of the pin trigger/timestamp control
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_top_properties
    import ptc_pkg::*;
#(
    parameter int N_CMP = 3,
    parameter int N_CAP = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // System time and pin
    input wire logic [31:0] sys_s,
    input wire logic [29:0] sys_ns,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe,
    // Unit events
    input wire logic [N_CMP-1:0] cmp_fire,
    input wire logic [N_CAP-1:0] capture_irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_take;
    assign rd_take = avs_read && avs_waitrequest;
    chk_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop after request");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_rdata_hold: assert property (!rd_take |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    chk_ns_reserved: assert property (
        rd_take && avs_address == `PTC_OFS_TGT_NS |=> avs_readdata[31:30] == 2'h0)
        else $error("nanosecond target upper bits not zero");
    chk_ctrl_level: assert property (
        rd_take && avs_address == `PTC_OFS_CTRL
        |=> avs_readdata[7] == $past(pin_in) && avs_readdata[31:9] == 23'h0)
        else $error("control read shows wrong pin level or reserved bits");
    chk_fire_once: assert property (
        (|cmp_fire) |=> (cmp_fire & $past(cmp_fire)) == '0)
        else $error("compare fire longer than one cycle");
    chk_pin_cause: assert property (
        pin_out |-> (|cmp_fire) || (|$past(cmp_fire)))
        else $error("pin output without a compare fire");
    chk_oe_by_write: assert property (
        $changed(pin_oe) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("pin direction changed without a write");
    chk_irq_cause: assert property (
        $rose(|capture_irq) |-> $past(avs_write) || $past(avs_write, 2)
        || $past(pin_in) || $past(pin_in, 2))
        else $error("capture interrupt without event or write");
endmodule
bind ptc_top ptc_top_properties #(.N_CMP(N_CMP), .N_CAP(N_CAP)) i_ptc_top_properties (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sys_s(sys_s),
    .sys_ns(sys_ns), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cmp_fire(cmp_fire), .capture_irq(capture_irq));

// [testbench/ptc_pin_model.sv]
// Outside pin model: resolves the pin level from both drivers
`timescale 1ns/10ps
module ptc_pin_model (
    // Clock
    input wire logic clk,
    // Block side
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    // ****************************************
    // Pin level
    // ****************************************
    logic ext_lvl = 1'h0;
    // Block drives while enabled, else the outside level
    assign pin_in = (pin_oe !== 1'h0) ? (pin_out === 1'h1) : ext_lvl;
    task automatic hold(input logic v);
        ext_lvl <= v;
        repeat (3) @(posedge clk);
    endtask
endmodule

// [testbench/ptc_top_tb.sv]
// Self-checking testbench of the pin trigger/timestamp control
`timescale 1ns/10ps
`include "ptc_cfg.svh"
module ptc_top_tb
    import ptc_pkg::*;
;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdv;
    logic avs_waitrequest, pin_in, pin_out, pin_oe;
    logic tick = 1'h0;
    logic [31:0] sys_s = 32'h1;
    logic [29:0] sys_ns = 30'h5A;
    logic [29:0] fns = 30'h0;
    logic [2:0] cmp_fire, fired = 3'h0, last = 3'h0;
    logic [1:0] capture_irq;
    logic p0 = 1'h0;
    logic p1 = 1'h0;
    int mismatches = 0;
    int checks = 0;
    ptc_top i_ptc_top (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sys_s(sys_s), .sys_ns(sys_ns),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .cmp_fire(cmp_fire),
        .capture_irq(capture_irq));
    ptc_pin_model i_ptc_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));
    initial begin
        forever #20 clk = ~clk;
    end
    // Time source and fire monitor
    always @(posedge clk) begin
        if (tick)
            sys_ns <= sys_ns + 30'h1;
        last <= cmp_fire;
        if (cmp_fire !== 3'h0) begin
            fired <= fired | cmp_fire;
            p0 <= pin_out;
            fns <= sys_ns;
        end
        if (last !== 3'h0)
            p1 <= pin_out;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        chk({31'h0, avs_waitrequest}, 32'h0);
        rdv = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'h1, d);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 32'h0);
        chk(rdv, e);
    endtask
    task automatic wfire(input int u);
        int n;
        n = 0;
        while (fired[u] !== 1'h1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk({31'h0, pin_oe}, 32'h1);
        rc(`PTC_OFS_CTRL, 32'h0);
        rc(`PTC_OFS_TGT_NS, 32'h0);
        rc(`PTC_OFS_TGT_S, 32'h0);
        rc(12'h5F0, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(`PTC_OFS_INDEX, 32'(i));
            wr(`PTC_OFS_TGT_NS, 32'hFFFF_FFF0 + 32'(i));
            wr(`PTC_OFS_TGT_S, 32'hA5A5_0000 + 32'(i));
        end
        for (int i = 0; i < 3; i++) begin
            wr(`PTC_OFS_INDEX, 32'(i));
            rc(`PTC_OFS_TGT_NS, 32'h3FFF_FFF0 + 32'(i));
            rc(`PTC_OFS_TGT_S, 32'hA5A5_0000 + 32'(i));
        end
        $display("test targets done");
        wr(`PTC_OFS_INDEX, 32'h0);
        wr(`PTC_OFS_TGT_S, 32'h1);
        wr(`PTC_OFS_TGT_NS, 32'h64);
        wr(`PTC_OFS_CFG, 32'h0100_0000);
        wr(`PTC_OFS_CTRL, 32'h8);
        rc(`PTC_OFS_CTRL, 32'h18);
        chk(32'(fired), 32'h0);
        tick <= 1'h1;
        wfire(0);
        tick <= 1'h0;
        chk(32'(fns), 32'h65);
        chk({30'h0, p0, p1}, 32'h1);
        rc(`PTC_OFS_CTRL, 32'h0);
        rc(`PTC_OFS_STAT, 32'h1);
        wr(`PTC_OFS_STAT, 32'h1);
        rc(`PTC_OFS_STAT, 32'h0);
        $display("test compare fire done");
        wr(`PTC_OFS_INDEX, 32'h1);
        wr(`PTC_OFS_TGT_S, 32'h0);
        wr(`PTC_OFS_CFG, 32'h0100_0000);
        wr(`PTC_OFS_CTRL, 32'h8);
        rc(`PTC_OFS_STAT, 32'h0002_0000);
        rc(`PTC_OFS_CTRL, 32'h8);
        chk(32'(fired), 32'h1);
        wr(`PTC_OFS_CTRL, 32'h0);
        rc(`PTC_OFS_STAT, 32'h0);
        wr(`PTC_OFS_CFG, 32'h0300_0000);
        wr(`PTC_OFS_CTRL, 32'h108);
        wfire(1);
        chk(32'(fired), 32'h3);
        chk({30'h0, p0, p1}, 32'h2);
        $display("test late target done");
        wr(`PTC_OFS_INDEX, 32'h2);
        wr(`PTC_OFS_TGT_S, 32'h10);
        wr(`PTC_OFS_CFG, 32'h0300_0000);
        wr(`PTC_OFS_CTRL, 32'h8);
        rc(`PTC_OFS_CTRL, 32'h18);
        wr(`PTC_OFS_INDEX, 32'h0);
        rc(`PTC_OFS_CTRL, 32'h0);
        wr(`PTC_OFS_INDEX, 32'h2);
        wr(`PTC_OFS_CTRL, 32'hC);
        rc(`PTC_OFS_CTRL, 32'h0);
        rc(`PTC_OFS_CFG, 32'h0);
        $display("test compare clear done");
        wr(`PTC_OFS_INDEX, 32'h100);
        wr(`PTC_OFS_CTRL, 32'h62);
        chk({31'h0, pin_oe}, 32'h0);
        i_ptc_pin_model.hold(1'h1);
        rc(`PTC_OFS_CTRL, 32'hE2);
        rc(`PTC_OFS_CFG, 32'h0100_0101);
        chk(32'(capture_irq), 32'h2);
        i_ptc_pin_model.hold(1'h0);
        wr(`PTC_OFS_CTRL, 32'hC2);
        chk(32'(capture_irq), 32'h0);
        rc(`PTC_OFS_CTRL, 32'h42);
        wr(`PTC_OFS_CTRL, 32'h40);
        rc(`PTC_OFS_CFG, 32'h0100_0000);
        wr(`PTC_OFS_CTRL, 32'h42);
        i_ptc_pin_model.hold(1'h1);
        i_ptc_pin_model.hold(1'h0);
        wr(`PTC_OFS_CTRL, 32'h42);
        rc(`PTC_OFS_CFG, 32'h0100_0001);
        wr(`PTC_OFS_CTRL, 32'h43);
        rc(`PTC_OFS_CFG, 32'h0100_0000);
        $display("test capture done");
        tally_and_finish();
    end
endmodule
